// ===== spm_pkg.sv
package spm_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 8;
    localparam int LINK_PULSE_NS = 120;
    localparam int LINK_PULSE_CYC = (LINK_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int GO_SLEEP_TICK_NS = 1000;
    localparam int GO_SLEEP_TICK_CYC = (GO_SLEEP_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [5:0] OFS_GLOBAL = 6'h00;
    localparam logic [5:0] OFS_GO_SLEEP = 6'h04;
    localparam logic [5:0] OFS_EEE = 6'h08;
    localparam logic [5:0] OFS_STATUS = 6'h0C;
    localparam logic [5:0] OFS_PHY_BASE = 6'h10;
    localparam logic [5:0] OFS_PORT_BASE = 6'h20;
    localparam int MODE_LSB = 3;
    localparam int MODE_MSB = 4;
    localparam int PHY_PD_BIT = 11;
    localparam int PORT_PD_BIT = 3;
    localparam int EEE_ADV_BIT = 0;
    localparam int ST_LSB = 0;
    localparam int ST_TX_LPI_BIT = 4;
    localparam int ST_PARTNER_BIT = 5;
    localparam int ST_EEE_ON_BIT = 6;
    localparam int ST_ENERGY_BIT = 7;
    localparam logic [7:0] GO_SLEEP_RST = 8'h20;
    localparam logic EEE_ADV_RST = 1'b1;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PM_NORMAL = 2'b00,
        PM_ENERGY = 2'b01,
        PM_SOFT_PD = 2'b10,
        PM_RSVD = 2'b11
    } spm_mode_t;

    typedef enum logic [3:0] {
        ST_FULL = 4'b0001,
        ST_ED_AWAKE = 4'b0010,
        ST_ED_SLEEP = 4'b0100,
        ST_SOFT_PD = 4'b1000
    } spm_state_t;

    typedef struct packed {
        logic en;
        logic er;
        logic [3:0] d;
    } spm_mii_tx_t;

    typedef struct packed {
        logic dv;
        logic er;
        logic [3:0] d;
    } spm_mii_rx_t;

    localparam spm_mii_tx_t LPI_TX = '{en: 1'b0, er: 1'b1, d: 4'h1};
    localparam spm_mii_rx_t LPI_RX = '{dv: 1'b0, er: 1'b1, d: 4'h1};
    localparam spm_mii_rx_t RX_IDLE = '{dv: 1'b0, er: 1'b0, d: 4'h0};

endpackage : spm_pkg

// ===== spm_power_eee.sv
// Summary of operation
// [RQ1] Mode field: 00 normal, 01 energy detect, 10 soft power-down, 11 reserved.
// [RQ2] Mode field resets to normal on hardware reset.
// [RQ3] Normal mode: clocks, PHYs, MACs and host interface all enabled.
// [RQ4] Host may write the mode field from normal to any other mode.
// [RQ5] Energy detect sleep: only receive energy detect stays on.
// [RQ6] No energy for longer than go-sleep time enters the sleep state.
// [RQ7] Energy seen while asleep returns to the normal power state.
// [RQ8] Energy detect mode keeps sending 120 ns link pulses.
// [RQ9] Soft power-down stops clocks, PHYs and MACs.
// [RQ10] Any host access in soft power-down wakes and resets all registers.
// [RQ11] Port PHY off when port control bit 3 or PHY control bit 11 set.
// [RQ12] Transmit and receive idle are handled independently per direction.
// [RQ13] Unused MAC and switch clocks are gated during idle.
// [RQ14] Carrier sense defers MAC transmit while idle is in force.
// [RQ15] Switch requests idle over MII and receives partner idle indication.
// [RQ16] Idle request drives Assert LPI on transmit MII and blocks the MAC.
// [RQ17] Request release restores idle encoding; MAC waits a wake delay.
// [RQ18] Receive signals pass through unchanged without Assert LPI.
// [RQ19] Assert LPI on receive presents idle and raises partner idle.
// [RQ20] Leaving Assert LPI drops partner idle and resumes decoding.
// [RQ21] Idle entry and exit never cut or corrupt a frame.
// [RQ22] Idle only when both ends advertised the capability.
// [RQ23] Wake delay is a parameterised cycle count.
//
// Added by the designer: the register offsets and the Avalon-MM interface to the registers.
module spm_power_eee
    import spm_pkg::*;
#(
    parameter int NP = 3,
    parameter int WAKE_CYCLES = 16,
    parameter int LINK_PULSE_PERIOD = 125000
) (
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic [5:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [3:0] AVS_BYTEENABLE,
    input wire logic [31:0] AVS_WRITEDATA,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    input wire logic [NP-1:0] ENERGY_DET,
    input wire logic AN_PARTNER_EEE,
    input wire logic SW_LPI_REQ,
    input wire spm_mii_tx_t MAC_TX,
    output spm_mii_tx_t MII_TX,
    output logic MAC_CRS,
    input wire spm_mii_rx_t MII_RX,
    output spm_mii_rx_t MAC_RX,
    output logic PARTNER_IDLE_INDICATION,
    output logic PLL_EN,
    output logic MAC_EN,
    output logic HOST_IF_EN,
    output logic [NP-1:0] PHY_EN,
    output logic ED_RX_EN,
    output logic LINK_PULSE,
    output logic TX_CLK_GATE,
    output logic RX_CLK_GATE,
    output logic SW_CLK_GATE
);

    localparam int PW = $clog2(LINK_PULSE_PERIOD);
    localparam int WW = $clog2(WAKE_CYCLES + 1);

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    function automatic logic port_hit(input logic [5:0] a, input logic [5:0] base, input int p);
        return a == 6'(base + 6'(p * 4));
    endfunction : port_hit

    function automatic spm_state_t state_for_mode(input spm_mode_t m);
        case (m)
            PM_ENERGY: return ST_ED_AWAKE;
            PM_SOFT_PD: return ST_SOFT_PD;
            default: return ST_FULL;
        endcase
    endfunction : state_for_mode

    // ------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------
    logic ack;
    logic access;
    logic wr_ok;
    logic soft_wake;
    logic clear;
    logic [31:0] rd_mux;
    spm_mode_t mode;
    logic [7:0] go_sleep;
    logic eee_adv;
    logic [NP-1:0] phy_pd;
    logic [NP-1:0] port_pd;
    spm_state_t state;
    spm_state_t next_state;
    logic tx_lpi;
    logic next_tx_lpi;
    logic eee_on;
    logic [NP-1:0] e1;
    logic [NP-1:0] e2;
    logic [NP-1:0] e3;
    logic [NP-1:0] energy_f;
    logic energy;

    assign access = AVS_READ | AVS_WRITE;
    assign AVS_WAITREQUEST = access & ~ack;
    assign wr_ok = AVS_WRITE & ack;
    assign soft_wake = (mode == PM_SOFT_PD) & access & ack; // RQ10
    assign clear = ~RSTN | soft_wake; // RQ10

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            ack <= 1'b0;
        end else begin
            ack <= access & ~ack;
        end
    end

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (AVS_ADDRESS)
            OFS_GLOBAL: rd_mux[MODE_MSB:MODE_LSB] = mode;
            OFS_GO_SLEEP: rd_mux[7:0] = go_sleep;
            OFS_EEE: rd_mux[EEE_ADV_BIT] = eee_adv;
            OFS_STATUS: begin
                rd_mux[ST_LSB +: 4] = state;
                rd_mux[ST_TX_LPI_BIT] = tx_lpi;
                rd_mux[ST_PARTNER_BIT] = PARTNER_IDLE_INDICATION;
                rd_mux[ST_EEE_ON_BIT] = eee_on;
                rd_mux[ST_ENERGY_BIT] = energy;
            end
            default: ;
        endcase
        for (int p = 0; p < NP; p++) begin
            if (port_hit(AVS_ADDRESS, OFS_PHY_BASE, p)) begin
                rd_mux[PHY_PD_BIT] = phy_pd[p];
            end
            if (port_hit(AVS_ADDRESS, OFS_PORT_BASE, p)) begin
                rd_mux[PORT_PD_BIT] = port_pd[p];
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            AVS_READDATA <= 32'h0000_0000;
        end else if (AVS_READ && !ack) begin
            AVS_READDATA <= rd_mux;
        end
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (clear) begin
            mode <= PM_NORMAL; // RQ2
            go_sleep <= GO_SLEEP_RST;
            eee_adv <= EEE_ADV_RST;
        end else if (wr_ok && AVS_BYTEENABLE[0]) begin
            if (AVS_ADDRESS == OFS_GLOBAL) begin
                mode <= spm_mode_t'(AVS_WRITEDATA[MODE_MSB:MODE_LSB]); // RQ4
            end
            if (AVS_ADDRESS == OFS_GO_SLEEP) begin
                go_sleep <= AVS_WRITEDATA[7:0];
            end
            if (AVS_ADDRESS == OFS_EEE) begin
                eee_adv <= AVS_WRITEDATA[EEE_ADV_BIT];
            end
        end
    end

    generate
        for (genvar g = 0; g < NP; g++) begin : g_port
            always_ff @(posedge CLK) begin
                if (clear) begin
                    phy_pd[g] <= 1'b0;
                    port_pd[g] <= 1'b0;
                end else if (wr_ok) begin
                    if (port_hit(AVS_ADDRESS, OFS_PHY_BASE, g) && AVS_BYTEENABLE[1]) begin
                        phy_pd[g] <= AVS_WRITEDATA[PHY_PD_BIT];
                    end
                    if (port_hit(AVS_ADDRESS, OFS_PORT_BASE, g) && AVS_BYTEENABLE[0]) begin
                        port_pd[g] <= AVS_WRITEDATA[PORT_PD_BIT];
                    end
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Energy detect input filter
    // ------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            e1 <= '0;
            e2 <= '0;
            e3 <= '0;
            energy_f <= '0;
        end else begin
            e1 <= ENERGY_DET;
            e2 <= e1;
            e3 <= e2;
            energy_f <= (e2 & e3) | (energy_f & (e2 | e3));
        end
    end

    assign energy = |energy_f;

    // ------------------------------------------------------------
    // Go-sleep timer
    // ------------------------------------------------------------
    logic [7:0] tick;
    logic [8:0] idle_units;

    always_ff @(posedge CLK) begin
        if (clear || state != ST_ED_AWAKE || energy) begin
            tick <= 8'h00;
            idle_units <= 9'h000;
        end else if (tick == 8'(GO_SLEEP_TICK_CYC - 1)) begin
            tick <= 8'h00;
            if (idle_units != 9'h1FF) begin
                idle_units <= idle_units + 9'h001;
            end
        end else begin
            tick <= tick + 8'h01;
        end
    end

    // ------------------------------------------------------------
    // Power state machine
    // ------------------------------------------------------------
    always_comb begin
        next_state = state_for_mode(mode); // RQ1
        case (state)
            ST_ED_AWAKE: begin
                if (mode == PM_ENERGY && !energy && idle_units > {1'b0, go_sleep}) begin
                    next_state = ST_ED_SLEEP; // RQ6
                end
            end
            ST_ED_SLEEP: begin
                if (mode == PM_ENERGY && !energy) begin
                    next_state = ST_ED_SLEEP;
                end
            end
            default: ;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (clear) begin
            state <= ST_FULL;
        end else begin
            state <= next_state; // RQ7
        end
    end

    always_ff @(posedge CLK) begin
        if (clear) begin
            PLL_EN <= 1'b1;
            MAC_EN <= 1'b1;
            HOST_IF_EN <= 1'b1;
            PHY_EN <= '1;
            ED_RX_EN <= 1'b1;
        end else begin
            case (next_state)
                ST_FULL, ST_ED_AWAKE: begin
                    PLL_EN <= 1'b1; // RQ3
                    MAC_EN <= 1'b1;
                    HOST_IF_EN <= 1'b1;
                    PHY_EN <= ~(port_pd | phy_pd); // RQ11
                    ED_RX_EN <= 1'b1;
                end
                ST_ED_SLEEP: begin
                    PLL_EN <= 1'b0; // RQ5
                    MAC_EN <= 1'b0;
                    HOST_IF_EN <= 1'b0;
                    PHY_EN <= '0;
                    ED_RX_EN <= 1'b1;
                end
                default: begin
                    PLL_EN <= 1'b0; // RQ9
                    MAC_EN <= 1'b0;
                    HOST_IF_EN <= 1'b0;
                    PHY_EN <= '0;
                    ED_RX_EN <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Link pulses
    // ------------------------------------------------------------
    logic [PW-1:0] pcnt;
    logic in_ed;

    assign in_ed = (state == ST_ED_AWAKE) || (state == ST_ED_SLEEP);

    always_ff @(posedge CLK) begin
        if (clear || !in_ed || pcnt == PW'(LINK_PULSE_PERIOD - 1)) begin
            pcnt <= '0;
        end else begin
            pcnt <= pcnt + PW'(1);
        end
    end

    always_ff @(posedge CLK) begin
        if (clear) begin
            LINK_PULSE <= 1'b0;
        end else begin
            LINK_PULSE <= in_ed && pcnt < PW'(LINK_PULSE_CYC); // RQ8
        end
    end

    // ------------------------------------------------------------
    // Idle assert path
    // ------------------------------------------------------------
    logic [WW-1:0] wake_cnt;

    assign eee_on = eee_adv & AN_PARTNER_EEE; // RQ22
    assign next_tx_lpi = eee_on & SW_LPI_REQ & (tx_lpi | ~MAC_TX.en); // RQ21
    assign MAC_CRS = tx_lpi | next_tx_lpi | (wake_cnt != '0); // RQ14

    always_ff @(posedge CLK) begin
        if (clear) begin
            tx_lpi <= 1'b0;
            MII_TX <= '0;
        end else begin
            tx_lpi <= next_tx_lpi; // RQ15
            MII_TX <= next_tx_lpi ? LPI_TX : MAC_TX; // RQ16
        end
    end

    always_ff @(posedge CLK) begin
        if (clear) begin
            wake_cnt <= '0;
        end else if (tx_lpi && !next_tx_lpi) begin
            wake_cnt <= WW'(WAKE_CYCLES); // RQ23
        end else if (wake_cnt != '0) begin
            wake_cnt <= wake_cnt - WW'(1); // RQ17
        end
    end

    // ------------------------------------------------------------
    // Idle detect path
    // ------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (clear) begin
            MAC_RX <= RX_IDLE;
            PARTNER_IDLE_INDICATION <= 1'b0;
        end else if (MII_RX == LPI_RX) begin
            MAC_RX <= RX_IDLE; // RQ19
            PARTNER_IDLE_INDICATION <= 1'b1;
        end else begin
            MAC_RX <= MII_RX; // RQ18
            PARTNER_IDLE_INDICATION <= 1'b0; // RQ20
        end
    end

    assign TX_CLK_GATE = tx_lpi; // RQ12
    assign RX_CLK_GATE = PARTNER_IDLE_INDICATION; // RQ13
    assign SW_CLK_GATE = tx_lpi & PARTNER_IDLE_INDICATION; // RQ13

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RSTN);

    sequence s_wake_hold;
        MAC_CRS [* 8];
    endsequence

    sequence s_release;
        ##[1:1000] !MAC_CRS;
    endsequence

    property p_reset_mode;
        $rose(RSTN) |-> mode == PM_NORMAL && state == ST_FULL;
    endproperty
    a_reset_mode: assert property (p_reset_mode) else $error("Mode not normal after reset"); // RQ2

    property p_normal_on;
        state == ST_FULL |-> PLL_EN && MAC_EN && HOST_IF_EN;
    endproperty
    a_normal_on: assert property (p_normal_on) else $error("Normal mode not fully on"); // RQ3

    property p_sleep_entry;
        state == ST_ED_AWAKE && mode == PM_ENERGY && !energy && idle_units > {1'b0, go_sleep}
            |=> state == ST_ED_SLEEP;
    endproperty
    a_sleep_entry: assert property (p_sleep_entry) else $error("Sleep not entered"); // RQ6

    property p_sleep_outputs;
        state == ST_ED_SLEEP |-> !PLL_EN && !MAC_EN && !HOST_IF_EN && PHY_EN == '0 && ED_RX_EN;
    endproperty
    a_sleep_outputs: assert property (p_sleep_outputs) else $error("Sleep enables wrong"); // RQ5

    property p_wake;
        state == ST_ED_SLEEP && mode == PM_ENERGY && energy |=> state == ST_ED_AWAKE && PLL_EN;
    endproperty
    a_wake: assert property (p_wake) else $error("No wake on energy"); // RQ7

    property p_pulse;
        $rose(LINK_PULSE) |-> (LINK_PULSE || !in_ed) [* 8];
    endproperty
    a_pulse: assert property (p_pulse) else $error("Link pulse too short"); // RQ8

    property p_soft_off;
        state == ST_SOFT_PD |-> !PLL_EN && !MAC_EN && PHY_EN == '0 && !ED_RX_EN;
    endproperty
    a_soft_off: assert property (p_soft_off) else $error("Soft power-down not off"); // RQ9

    property p_soft_wake;
        mode == PM_SOFT_PD && access && !AVS_WAITREQUEST
            |=> mode == PM_NORMAL && go_sleep == GO_SLEEP_RST && state == ST_FULL;
    endproperty
    a_soft_wake: assert property (p_soft_wake) else $error("Soft wake failed"); // RQ10

    property p_port_pd;
        port_pd[0] || phy_pd[0] |=> !PHY_EN[0];
    endproperty
    a_port_pd: assert property (p_port_pd) else $error("Port 0 PHY not off"); // RQ11

    property p_lpi_block;
        tx_lpi |-> MII_TX == LPI_TX && MAC_CRS;
    endproperty
    a_lpi_block: assert property (p_lpi_block) else $error("Idle encoding missing"); // RQ16

    property p_wake_delay;
        $fell(tx_lpi) |-> s_wake_hold ##0 s_release;
    endproperty
    a_wake_delay: assert property (p_wake_delay) else $error("Wake delay wrong"); // RQ17

    property p_no_eee;
        !eee_on |=> !tx_lpi;
    endproperty
    a_no_eee: assert property (p_no_eee) else $error("Idle without capability"); // RQ22

    property p_rx_enter;
        MII_RX == LPI_RX |=> PARTNER_IDLE_INDICATION && MAC_RX == RX_IDLE;
    endproperty
    a_rx_enter: assert property (p_rx_enter) else $error("Partner idle not shown"); // RQ19

    property p_rx_pass;
        MII_RX != LPI_RX && !soft_wake |=> !PARTNER_IDLE_INDICATION && MAC_RX == $past(MII_RX);
    endproperty
    a_rx_pass: assert property (p_rx_pass) else $error("Receive not passed"); // RQ18

endmodule : spm_power_eee

// ===== spm_phy_model.sv
module spm_phy_model
    import spm_pkg::*;
(
    input wire logic clk,
    input wire logic lpi_on,
    output spm_mii_rx_t mii_rx
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // Receive side of the port PHY
    // ------------------------------------------------------------
    integer seed = 35;

    // Normal data keeps er low, so it never looks like the idle code
    always @(posedge clk) begin
        if (lpi_on) begin
            mii_rx <= LPI_RX;
        end else begin
            mii_rx <= '{dv: 1'($random(seed)), er: 1'b0, d: 4'($random(seed))};
        end
    end

endmodule : spm_phy_model

// ===== spm_power_eee_tb.sv
module spm_power_eee_tb
    import spm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    localparam int WAKE = 16;
    localparam int LPP = 64;
    typedef struct packed {logic [31:0] exp; logic [31:0] mask;} spm_exp_t;
    logic clk, rstn, rd, wr, wait_req, an_eee, lpi_req, rx_lpi, rx_chk, crs, pidle;
    logic pll_en, mac_en, host_en, ed_en, pulse, txg, rxg, swg;
    logic [5:0] addr;
    logic [31:0] wdata, rdata;
    logic [2:0] energy, phy_en;
    spm_mii_tx_t mac_tx, mii_tx;
    spm_mii_rx_t mii_rx, mac_rx;
    int n_fail = 0;
    int cmp_count = 0;
    int n, g;
    integer seed = 35;
    spm_exp_t rd_q[$];
    spm_exp_t rd_e;
    logic [6:0] rx_q[$];
    spm_mode_t mseq[4] = '{PM_RSVD, PM_NORMAL, PM_ENERGY, PM_NORMAL};
    spm_state_t sseq[4] = '{ST_FULL, ST_FULL, ST_ED_AWAKE, ST_FULL};

    spm_power_eee #(.NP(3), .WAKE_CYCLES(WAKE), .LINK_PULSE_PERIOD(LPP)) u_spm_power_eee (
        .CLK(clk), .RSTN(rstn), .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
        .AVS_BYTEENABLE(4'hF), .AVS_WRITEDATA(wdata), .AVS_READDATA(rdata),
        .AVS_WAITREQUEST(wait_req), .ENERGY_DET(energy), .AN_PARTNER_EEE(an_eee),
        .SW_LPI_REQ(lpi_req), .MAC_TX(mac_tx), .MII_TX(mii_tx), .MAC_CRS(crs),
        .MII_RX(mii_rx), .MAC_RX(mac_rx), .PARTNER_IDLE_INDICATION(pidle),
        .PLL_EN(pll_en), .MAC_EN(mac_en), .HOST_IF_EN(host_en), .PHY_EN(phy_en),
        .ED_RX_EN(ed_en), .LINK_PULSE(pulse), .TX_CLK_GATE(txg), .RX_CLK_GATE(rxg),
        .SW_CLK_GATE(swg)
    );

    spm_phy_model u_spm_phy_model (.clk(clk), .lpi_on(rx_lpi), .mii_rx(mii_rx));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic complete_run;
        $display("Checks %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : complete_run

    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        int k = 0;
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= w;
        rd <= !w;
        do begin
            @(posedge clk);
            k++;
        end while (wait_req !== 1'b0 && k < 20);
        if (k >= 20) chk("bus_answer", 32'h0, 32'h1);
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus

    task automatic rd_chk(input logic [5:0] a, input logic [31:0] e, input logic [31:0] m);
        rd_q.push_back('{exp: e, mask: m});
        bus(1'b0, a, 32'h0);
    endtask : rd_chk

    task automatic wait_neg(input int lim);
        repeat (lim) @(negedge clk);
    endtask : wait_neg

    // ------------------------------------------------------------
    // Monitors
    // ------------------------------------------------------------
    always @(posedge clk) begin
        if (rd && !wait_req && rd_q.size() > 0) begin
            rd_e = rd_q.pop_front();
            chk("readdata", rdata & rd_e.mask, rd_e.exp & rd_e.mask);
        end
        if (rx_chk) rx_q.push_back(mii_rx === LPI_RX ? {1'b1, RX_IDLE} : {1'b0, mii_rx});
    end

    always @(negedge clk) begin
        if (rx_chk && rx_q.size() > 0) chk("mac_rx", 32'({pidle, mac_rx}), 32'(rx_q.pop_front()));
    end

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    initial begin
        repeat (20000) @(posedge clk);
        chk("watchdog", 32'h0, 32'h1);
        complete_run();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        rstn = 1'b0;
        addr = 6'h00;
        rd = 1'b0;
        wr = 1'b0;
        wdata = 32'h0;
        energy = 3'h7;
        an_eee = 1'b1;
        lpi_req = 1'b0;
        rx_lpi = 1'b0;
        rx_chk = 1'b0;
        mac_tx = '0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        rd_chk(OFS_GLOBAL, 32'h0, 32'h18);
        rd_chk(OFS_GO_SLEEP, 32'(GO_SLEEP_RST), 32'hFF);
        rd_chk(OFS_EEE, 32'(EEE_ADV_RST), 32'h1);
        rd_chk(OFS_STATUS, 32'hC1, 32'hFF);
        rd_chk(6'h3C, 32'h0, 32'hFFFFFFFF);
        @(negedge clk);
        chk("enables", 32'({pll_en, mac_en, host_en, ed_en, phy_en, pulse}), 32'hFE);
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, OFS_GLOBAL, 32'({mseq[i], 3'b000}));
            rd_chk(OFS_STATUS, 32'(sseq[i]), 32'hF);
        end
        // Energy detect sleep and wake
        g = 1 + ($random(seed) & 1);
        bus(1'b1, OFS_GO_SLEEP, 32'(g));
        bus(1'b1, OFS_GLOBAL, 32'({PM_ENERGY, 3'b000}));
        @(posedge clk);
        energy <= 3'h0;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (pll_en !== 1'b0 && n < (g + 2) * 125 + 20);
        chk("sleep_min", 32'(n > g * 125), 32'h1);
        chk("sleep_max", 32'(n < (g + 2) * 125 + 20), 32'h1);
        chk("sleep_en", 32'({pll_en, mac_en, host_en, ed_en}), 32'h1);
        n = 0;
        while (pulse === 1'b1 && n < 50) begin
            @(negedge clk);
            n++;
        end
        n = 0;
        while (pulse !== 1'b1 && n < 200) begin
            @(negedge clk);
            n++;
        end
        n = 0;
        while (pulse === 1'b1 && n < 50) begin
            @(negedge clk);
            n++;
        end
        chk("pulse_width", 32'(n), 32'(LINK_PULSE_CYC));
        while (pulse !== 1'b1 && n < 200) begin
            @(negedge clk);
            n++;
        end
        chk("pulse_period", 32'(n), 32'(LPP));
        @(posedge clk);
        energy <= 3'h7;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (pll_en !== 1'b1 && n < 20);
        chk("wake_time", 32'(n <= 8), 32'h1);
        rd_chk(OFS_STATUS, 32'(ST_ED_AWAKE), 32'hF);
        // Soft power-down and wake by any access
        bus(1'b1, OFS_GLOBAL, 32'({PM_NORMAL, 3'b000}));
        bus(1'b1, OFS_GO_SLEEP, 32'h55);
        bus(1'b1, OFS_EEE, 32'h0);
        bus(1'b1, OFS_GLOBAL, 32'({PM_SOFT_PD, 3'b000}));
        wait_neg(2);
        chk("soft_pd_en", 32'({pll_en, mac_en, host_en, phy_en}), 32'h0);
        bus(1'b1, 6'h3C, 32'h0);
        rd_chk(OFS_GLOBAL, 32'h0, 32'h18);
        rd_chk(OFS_GO_SLEEP, 32'(GO_SLEEP_RST), 32'hFF);
        rd_chk(OFS_EEE, 32'(EEE_ADV_RST), 32'h1);
        chk("woken_en", 32'({pll_en, mac_en, host_en, phy_en}), 32'h3F);
        // Per-port power-down through both registers
        for (int p = 0; p < 3; p++) begin
            for (int k = 0; k < 2; k++) begin
                bus(1'b1, 6'((k ? OFS_PHY_BASE : OFS_PORT_BASE) + 4 * p), k ? 32'h800 : 32'h8);
                wait_neg(2);
                chk("phy_pd", 32'(phy_en), 32'(3'h7 & ~(3'h1 << p)));
                bus(1'b1, 6'((k ? OFS_PHY_BASE : OFS_PORT_BASE) + 4 * p), 32'h0);
                wait_neg(2);
                chk("phy_on", 32'(phy_en), 32'h7);
            end
        end
        // Idle request refused without both advertisements
        for (int k = 0; k < 2; k++) begin
            bus(1'b1, OFS_EEE, 32'(k == 0));
            @(posedge clk);
            an_eee <= k[0];
            lpi_req <= 1'b1;
            wait_neg(4);
            chk("no_lpi", 32'({mii_tx, crs}), 32'h0);
            @(posedge clk);
            lpi_req <= 1'b0;
        end
        bus(1'b1, OFS_EEE, 32'h1);
        // Transmit idle with a frame in flight, receive data flowing
        @(posedge clk);
        rx_chk <= 1'b1;
        mac_tx <= '{en: 1'b1, er: 1'b0, d: 4'($random(seed))};
        @(posedge clk);
        lpi_req <= 1'b1;
        wait_neg(2);
        chk("frame_kept", 32'(mii_tx), 32'(mac_tx));
        @(posedge clk);
        mac_tx <= '{en: 1'b0, er: 1'b0, d: 4'($random(seed))};
        wait_neg(3);
        chk("lpi_tx", 32'(mii_tx), 32'(LPI_TX));
        chk("defer", 32'({crs, txg}), 32'h3);
        repeat (4) @(posedge clk);
        lpi_req <= 1'b0;
        wait_neg(2);
        chk("resume_tx", 32'(mii_tx), 32'(mac_tx));
        n = 0;
        while (crs === 1'b1 && n < 100) begin
            n++;
            @(negedge clk);
        end
        chk("wake_delay", 32'(n), 32'(WAKE));
        // Receive idle, alone and with transmit idle
        @(posedge clk);
        rx_lpi <= 1'b1;
        wait_neg(4);
        chk("rx_gates", 32'({rxg, txg, swg}), 32'h4);
        @(posedge clk);
        lpi_req <= 1'b1;
        wait_neg(3);
        chk("all_gates", 32'({rxg, txg, swg}), 32'h7);
        @(posedge clk);
        lpi_req <= 1'b0;
        rx_lpi <= 1'b0;
        repeat (6) @(posedge clk);
        rx_chk <= 1'b0;
        @(posedge clk);
        rx_q.delete();
        complete_run();
    end

endmodule : spm_power_eee_tb
